// ---- include/cpu_irq_regs.vh ----
// register offsets, field positions, reset values and timing figures of the interrupt controller
`ifndef CPU_IRQ_REGS_VH
`define CPU_IRQ_REGS_VH

`define IRQ_NUM_SRC          12
`define IRQ_IDX_W            4
`define IRQ_SRC_IMPL         12'hE7F

`define IRQ_ENABLE_OFS       8'h00
`define IRQ_EXT_ENABLE_OFS   8'h04
`define IRQ_PRIORITY_OFS     8'h08
`define IRQ_EXT_PRIORITY_OFS 8'h0C
`define IRQ_PEND_OFS         8'h10
`define IRQ_PEND_CLR_OFS     8'h14
`define IRQ_STATE_OFS        8'h18
`define IRQ_EVT_STAT_OFS     8'h1C
`define IRQ_EVT_MASK_OFS     8'h20

`define IRQ_GLOBAL_BIT       7
`define IRQ_EXT_LO           2
`define IRQ_EXT_HI           4
`define IRQ_EXT_FIRST_SRC    9

`define IRQ_ENABLE_RST       8'h00
`define IRQ_PRIORITY_RST     8'h00
`define IRQ_PEND_RST         12'h000
`define IRQ_EVT_RST          3'h0

`define IRQ_EVT_VECTORED     0
`define IRQ_EVT_RETURNED     1
`define IRQ_EVT_PREEMPTED    2
`define IRQ_EVT_W            3

`define IRQ_VECTOR_BASE      16'h0003
`define IRQ_VECTOR_STEP      16'h0008

`define IRQ_DETECT_CYCLES    1
`define IRQ_CALL_CYCLES      4

`endif

// ---- rtl/lowest_pick.v ----
// picks the lowest-numbered set bit of a request vector
module lowest_pick #(
    parameter N = 12,
    parameter W = 4
) (
    input  wire [N-1:0] req,
    output reg          found,
    output reg  [W-1:0] idx
);
    integer i;
    always @* begin
        found = 1'b0;
        idx   = {W{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                found = 1'b1;
                idx   = i[W-1:0];
            end
        end
    end
endmodule

// ---- rtl/cpu_interrupt_controller.v ----
// interrupt controller of the cpu core with an ahb-lite register slave
`include "cpu_irq_regs.vh"
module cpu_interrupt_controller #(
    parameter NSRC = `IRQ_NUM_SRC,
    parameter IW   = `IRQ_IDX_W
) (
    input  wire            ref_clk,
    input  wire            rst,
    input  wire            hsel,
    input  wire [31:0]     haddr,
    input  wire [1:0]      htrans,
    input  wire            hwrite,
    input  wire [2:0]      hsize,
    input  wire [31:0]     hwdata,
    input  wire            hready,
    output reg  [31:0]     hrdata,
    output reg             hreadyout,
    output reg             hresp,
    input  wire [NSRC-1:0] src_event,
    input  wire            insn_end,
    input  wire            next_single,
    input  wire            vector_ack,
    input  wire            reti_done,
    output reg             cpu_irq_req,
    output reg             cpu_irq_high,
    output reg  [IW-1:0]   cpu_irq_idx,
    output reg  [15:0]     cpu_irq_vector,
    output reg             irq_out
);
    reg  [7:0]                 irq_enable_reg_r;
    reg  [7:0]                 ext_irq_enable_reg_r;
    reg  [7:0]                 irq_priority_reg_r;
    reg  [7:0]                 ext_irq_priority_reg_r;
    reg  [NSRC-1:0]            pend_r;
    reg  [NSRC-1:0]            grace_r;
    reg                        low_act_r;
    reg                        high_act_r;
    reg                        hold_r;
    reg  [`IRQ_EVT_W-1:0]      evt_stat_r;
    reg  [`IRQ_EVT_W-1:0]      evt_mask_r;
    reg                        wr_pend_r;
    reg  [7:0]                 wr_ofs_r;
    reg                        rd_pend_r;
    reg  [7:0]                 rd_ofs_r;

    reg  [NSRC-1:0]            pend_nxt;
    reg  [NSRC-1:0]            grace_nxt;
    reg  [`IRQ_EVT_W-1:0]      evt_nxt;
    reg  [7:0]                 ie_nxt;
    reg  [7:0]                 eie_nxt;
    reg  [31:0]                rd_val;
    reg                        drop_req;
    reg                        late_block;

    wire                       addr_ok;
    wire [NSRC-1:0]            en_vec;
    wire [NSRC-1:0]            en_new_vec;
    wire [NSRC-1:0]            pri_vec;
    wire [NSRC-1:0]            cand;
    wire [NSRC-1:0]            cand_hi;
    wire [NSRC-1:0]            cand_lo;
    wire                       hi_found;
    wire                       lo_found;
    wire [IW-1:0]              hi_idx;
    wire [IW-1:0]              lo_idx;
    wire                       take_hi;
    wire                       take_lo;
    wire                       wr_now;
    wire [IW-1:0]              sel_idx;

    // map both enable/priority byte pairs onto the ten implemented source numbers 0-6 and 9-11
    function [NSRC-1:0] src_map;
        input [7:0] base;
        input [7:0] ext;
        begin
            src_map = {NSRC{1'b0}};
            src_map[6:0] = base[6:0];
            src_map[`IRQ_EXT_FIRST_SRC+2:`IRQ_EXT_FIRST_SRC] = ext[`IRQ_EXT_HI:`IRQ_EXT_LO];
            src_map = src_map & `IRQ_SRC_IMPL;
        end
    endfunction

    function [NSRC-1:0] en_map;
        input [7:0] base;
        input [7:0] ext;
        begin
            en_map = base[`IRQ_GLOBAL_BIT] ? src_map(base, ext) : {NSRC{1'b0}};
        end
    endfunction

    // service routine entry address of a source number
    function [15:0] vec_of;
        input [IW-1:0] idx;
        begin
            vec_of = `IRQ_VECTOR_BASE + `IRQ_VECTOR_STEP * {{(16-IW){1'b0}}, idx};
        end
    endfunction

    assign addr_ok    = hsel & htrans[1] & hready;
    assign wr_now     = wr_pend_r;
    assign en_vec     = en_map(irq_enable_reg_r, ext_irq_enable_reg_r);
    assign en_new_vec = en_map(ie_nxt, eie_nxt);
    assign pri_vec    = src_map(irq_priority_reg_r, ext_irq_priority_reg_r);
    // disabled flags are ignored; grace keeps a just-cleared enable for one instruction
    assign cand    = pend_r & (en_vec | grace_r);
    assign cand_hi = cand & pri_vec;
    assign cand_lo = cand & ~pri_vec;
    assign take_hi = hi_found & ~high_act_r;
    assign take_lo = lo_found & ~high_act_r & ~low_act_r;
    assign sel_idx = take_hi ? hi_idx : lo_idx;

    lowest_pick #(.N(NSRC), .W(IW)) pick_hi (
        .req   (cand_hi),
        .found (hi_found),
        .idx   (hi_idx)
    );

    lowest_pick #(.N(NSRC), .W(IW)) pick_lo (
        .req   (cand_lo),
        .found (lo_found),
        .idx   (lo_idx)
    );

    // register writes land in the data phase
    always @* begin
        ie_nxt  = irq_enable_reg_r;
        eie_nxt = ext_irq_enable_reg_r;
        if (wr_now && wr_ofs_r == `IRQ_ENABLE_OFS)
            ie_nxt = hwdata[7:0];
        if (wr_now && wr_ofs_r == `IRQ_EXT_ENABLE_OFS)
            eie_nxt = hwdata[7:0];
    end

    always @* begin
        pend_nxt   = pend_r;
        evt_nxt    = evt_stat_r;
        grace_nxt  = grace_r;
        drop_req   = 1'b0;
        late_block = 1'b0;
        if (insn_end)
            grace_nxt = {NSRC{1'b0}};
        if (wr_now && (en_vec & ~en_new_vec) != {NSRC{1'b0}}) begin
            if (next_single) begin
                grace_nxt = grace_r | (en_vec & ~en_new_vec);
            end else begin
                // a request decoded from the old enables must not issue
                late_block = 1'b1;
                drop_req   = cpu_irq_req & ~en_new_vec[cpu_irq_idx] & ~grace_r[cpu_irq_idx];
            end
        end
        if (wr_now && wr_ofs_r == `IRQ_PEND_CLR_OFS)
            pend_nxt = pend_r & ~hwdata[NSRC-1:0];
        if (wr_now && wr_ofs_r == `IRQ_EVT_STAT_OFS)
            evt_nxt = evt_stat_r & ~hwdata[`IRQ_EVT_W-1:0];
        // sets win over clears; vectoring never clears a flag
        pend_nxt = pend_nxt | src_event;
        if (wr_now && wr_ofs_r == `IRQ_PEND_OFS)
            pend_nxt = pend_nxt | hwdata[NSRC-1:0];
        pend_nxt = pend_nxt & `IRQ_SRC_IMPL;
        if (cpu_irq_req && vector_ack) begin
            evt_nxt[`IRQ_EVT_VECTORED] = 1'b1;
            if (cpu_irq_high && low_act_r)
                evt_nxt[`IRQ_EVT_PREEMPTED] = 1'b1;
        end
        if (reti_done)
            evt_nxt[`IRQ_EVT_RETURNED] = 1'b1;
    end

    always @* begin
        rd_val = 32'h0000_0000;
        case (rd_ofs_r)
            `IRQ_ENABLE_OFS:       rd_val[7:0] = irq_enable_reg_r;
            `IRQ_EXT_ENABLE_OFS:   rd_val[7:0] = ext_irq_enable_reg_r;
            `IRQ_PRIORITY_OFS:     rd_val[7:0] = irq_priority_reg_r;
            `IRQ_EXT_PRIORITY_OFS: rd_val[7:0] = ext_irq_priority_reg_r;
            `IRQ_PEND_OFS:         rd_val[NSRC-1:0] = pend_r;
            `IRQ_STATE_OFS:        rd_val[8:0] = {hold_r, cpu_irq_high, cpu_irq_req, high_act_r, low_act_r,
                                                  cpu_irq_idx};
            `IRQ_EVT_STAT_OFS:     rd_val[`IRQ_EVT_W-1:0] = evt_stat_r;
            `IRQ_EVT_MASK_OFS:     rd_val[`IRQ_EVT_W-1:0] = evt_mask_r;
            default:               rd_val = 32'h0000_0000;
        endcase
    end

    // ahb-lite slave: writes zero wait, reads one wait state so a preceding write is seen
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r  <= 8'h00;
            rd_pend_r <= 1'b0;
            rd_ofs_r  <= 8'h00;
            hreadyout <= 1'b1;
            hrdata    <= 32'h0000_0000;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= addr_ok & hwrite;
            rd_pend_r <= addr_ok & ~hwrite;
            if (addr_ok) begin
                wr_ofs_r <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
                rd_ofs_r <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
            end
            hreadyout <= ~(addr_ok & ~hwrite);
            if (rd_pend_r)
                hrdata <= rd_val;
            hresp <= 1'b0;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_enable_reg_r       <= `IRQ_ENABLE_RST;
            ext_irq_enable_reg_r   <= `IRQ_ENABLE_RST;
            irq_priority_reg_r     <= `IRQ_PRIORITY_RST;
            ext_irq_priority_reg_r <= `IRQ_PRIORITY_RST;
            pend_r                 <= `IRQ_PEND_RST;
            grace_r                <= `IRQ_PEND_RST;
            evt_stat_r             <= `IRQ_EVT_RST;
            evt_mask_r             <= `IRQ_EVT_RST;
            irq_out                <= 1'b0;
        end else begin
            irq_enable_reg_r     <= ie_nxt;
            ext_irq_enable_reg_r <= eie_nxt;
            if (wr_now && wr_ofs_r == `IRQ_PRIORITY_OFS)
                irq_priority_reg_r <= hwdata[7:0];
            if (wr_now && wr_ofs_r == `IRQ_EXT_PRIORITY_OFS)
                ext_irq_priority_reg_r <= hwdata[7:0];
            if (wr_now && wr_ofs_r == `IRQ_EVT_MASK_OFS)
                evt_mask_r <= hwdata[`IRQ_EVT_W-1:0];
            pend_r     <= pend_nxt;
            grace_r    <= grace_nxt;
            evt_stat_r <= evt_nxt;
            irq_out    <= |(evt_nxt & evt_mask_r);
        end
    end

    // request issue, hold and the nesting levels
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cpu_irq_req    <= 1'b0;
            cpu_irq_high   <= 1'b0;
            cpu_irq_idx    <= {IW{1'b0}};
            cpu_irq_vector <= `IRQ_VECTOR_BASE;
            low_act_r      <= 1'b0;
            high_act_r     <= 1'b0;
            hold_r         <= 1'b0;
        end else begin
            if (reti_done)
                hold_r <= 1'b1;
            else if (insn_end)
                hold_r <= 1'b0;
            if (reti_done) begin
                if (high_act_r)
                    high_act_r <= 1'b0;
                else
                    low_act_r <= 1'b0;
            end
            if (cpu_irq_req) begin
                if (vector_ack) begin
                    cpu_irq_req <= 1'b0;
                    if (cpu_irq_high)
                        high_act_r <= 1'b1;
                    else
                        low_act_r <= 1'b1;
                end else if (drop_req) begin
                    cpu_irq_req <= 1'b0;
                end
            end else if (!hold_r && !reti_done && !late_block && (take_hi || take_lo)) begin
                // decoded every cycle; lowest number wins within a level
                cpu_irq_req    <= 1'b1;
                cpu_irq_high   <= take_hi;
                cpu_irq_idx    <= sel_idx;
                cpu_irq_vector <= vec_of(sel_idx);
            end
        end
    end
endmodule

// ---- testbench/cpu_irq_asserts.sv ----
// concurrent checks on the interrupt controller ports
module cpu_irq_asserts #(
    parameter IW = 4
) (
    input wire logic          ref_clk,
    input wire logic          rst,
    input wire logic          hsel,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic          vector_ack,
    input wire logic          reti_done,
    input wire logic          cpu_irq_req,
    input wire logic          cpu_irq_high,
    input wire logic [IW-1:0] cpu_irq_idx,
    input wire logic [15:0]   cpu_irq_vector
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire take = hsel && htrans[1] && hready;
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
    property p_wr_ready; take && hwrite |=> hreadyout; endproperty
    a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
    property p_vec; cpu_irq_req |-> cpu_irq_vector == 16'h0003 + {cpu_irq_idx, 3'h0}; endproperty
    a_vec: assert property (p_vec) else $error("vector address wrong");
    property p_idx; cpu_irq_req |-> cpu_irq_idx < 4'hC && cpu_irq_idx != 4'h7 && cpu_irq_idx != 4'h8; endproperty
    a_idx: assert property (p_idx) else $error("source index out of set");
    property p_hold;
        cpu_irq_req && !vector_ack ##1 cpu_irq_req |-> $stable(cpu_irq_idx) && $stable(cpu_irq_high);
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before ack");
    property p_ack; cpu_irq_req && vector_ack |=> !cpu_irq_req; endproperty
    a_ack: assert property (p_ack) else $error("request kept after ack");
    property p_reti; reti_done && !cpu_irq_req |=> !cpu_irq_req; endproperty
    a_reti: assert property (p_reti) else $error("request right at return");
    property p_rise; $rose(cpu_irq_req) |-> !$past(reti_done); endproperty
    a_rise: assert property (p_rise) else $error("request raised on return cycle");
endmodule

bind cpu_interrupt_controller cpu_irq_asserts #(.IW(IW)) u_chk (.ref_clk, .rst, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .hresp, .vector_ack, .reti_done, .cpu_irq_req, .cpu_irq_high, .cpu_irq_idx,
    .cpu_irq_vector);

// ---- testbench/cpu_core_model.sv ----
// cpu core model: takes vectors, runs routines, returns
module cpu_core_model (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic cpu_irq_req,
    output logic      vector_ack,
    output logic      reti_done,
    output logic      insn_end,
    output logic      busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] free_r;
    logic [1:0] wait_r;
    logic [5:0] tmr_r;
    logic [2:0] depth_r;
    assign busy = depth_r != 3'h0;
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {free_r, wait_r, tmr_r, depth_r, vector_ack, reti_done, insn_end} <= '0;
        end else begin
            free_r <= free_r + 2'h1;
            insn_end <= free_r == 2'h3;
            vector_ack <= 1'b0;
            reti_done <= 1'b0;
            if (cpu_irq_req && !vector_ack && wait_r != 2'h0) begin
                wait_r <= wait_r - 2'h1;
            end else if (cpu_irq_req && !vector_ack) begin
                vector_ack <= 1'b1;
                depth_r <= depth_r + 3'h1;
                tmr_r <= 6'h1E;
                wait_r <= 2'($urandom % 4);
            end else if (busy && tmr_r == 6'h0) begin
                reti_done <= 1'b1;
                depth_r <= depth_r - 3'h1;
                tmr_r <= 6'h1E;
            end else if (busy) begin
                tmr_r <= tmr_r - 6'h1;
            end
        end
    end
endmodule

// ---- testbench/test_cpu_interrupt_controller.sv ----
// self-checking bench of the interrupt controller
module test_cpu_interrupt_controller;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [11:0] src_event = 12'h000;
    logic        next_single = 1'b0;
    wire         hreadyout, hresp, insn_end, vector_ack, reti_done, cpu_irq_req, cpu_irq_high, irq_out, busy;
    wire  [31:0] hrdata;
    wire  [3:0]  cpu_irq_idx;
    wire  [15:0] cpu_irq_vector;
    logic [4:0]  acks[$];
    logic [11:0] pri_m = 12'h000;
    int          n_mismatch = 0;
    int          n_checks = 0;
    logic [31:0] d;
    cpu_interrupt_controller dut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .src_event, .insn_end, .next_single, .vector_ack,
        .reti_done, .cpu_irq_req, .cpu_irq_high, .cpu_irq_idx, .cpu_irq_vector, .irq_out);
    cpu_core_model cpu (.ref_clk, .rst, .cpu_irq_req, .vector_ack, .reti_done, .insn_end, .busy);
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (vector_ack === 1'b1 && cpu_irq_req === 1'b1) acks.push_back({cpu_irq_high, cpu_irq_idx});
    function automatic logic [31:0] pend_of(input logic [31:0] v);
        return v & 32'h00000E7F;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        @(posedge ref_clk);
        {hsel, htrans, hwrite} <= {1'b1, 2'h2, w};
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] q;
        bus(1'b1, a, v, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic ack(input logic [3:0] i);
        repeat (200) if (acks.size() == 0) @(posedge ref_clk);
        chk(acks.size() ? {27'h0, acks.pop_front()} : 32'hFFFFFFFF, {27'h0, pri_m[i], i});
    endtask
    task automatic idle;
        repeat (300) if (busy !== 1'b0) @(posedge ref_clk);
        repeat (12) @(posedge ref_clk);
        chk(32'(acks.size()), 32'h0);
    endtask
    task automatic ev(input logic [11:0] m);
        @(posedge ref_clk);
        src_event <= m;
        @(posedge ref_clk);
        src_event <= 12'h000;
    endtask
    task automatic clr_evt;
        wr(8'h1C, 32'h7);
        repeat (2) @(posedge ref_clk);
        chk(irq_out, 32'h0);
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #300us;
        n_mismatch++;
        complete_run;
    end
    initial begin
        void'($urandom(76));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++) rd(8'(a * 4), 32'h0);
        wr(8'h24, 32'hFFFFFFFF);
        rd(8'h24, 32'h0);
        rd(8'h14, 32'h0);
        for (int k = 0; k < 8; k++) begin
            d = $urandom;
            ev(d[11:0]);
            rd(8'h10, pend_of(d));
            wr(8'h14, 32'hFFF);
            wr(8'h10, d);
            rd(8'h10, pend_of(d));
            wr(8'h14, 32'hFFF);
            wr(8'h04, d);
            rd(8'h04, d & 32'hFF);
        end
        wr(8'h04, 32'h0);
        chk(32'(acks.size()), 32'h0);
        wr(8'h00, 32'h80);
        ev(12'h008);
        repeat (20) @(posedge ref_clk);
        chk(32'(acks.size()), 32'h0);
        wr(8'h00, 32'h08);
        repeat (20) @(posedge ref_clk);
        chk(32'(acks.size()), 32'h0);
        wr(8'h20, 32'h1);
        wr(8'h00, 32'h88);
        ack(4'h3);
        rd(8'h10, 32'h8);
        chk(irq_out, 32'h1);
        wr(8'h14, 32'h8);
        clr_evt;
        idle;
        wr(8'h04, 32'h08);
        wr(8'h10, 32'h400);
        ack(4'hA);
        ack(4'hA);
        wr(8'h14, 32'h400);
        idle;
        wr(8'h04, 32'h0);
        wr(8'h00, 32'hA4);
        wr(8'h10, 32'h24);
        ack(4'h2);
        wr(8'h14, 32'h4);
        ack(4'h5);
        wr(8'h14, 32'h20);
        idle;
        wr(8'h08, 32'h40);
        pri_m = 12'h040;
        wr(8'h00, 32'hC1);
        wr(8'h20, 32'h4);
        wr(8'h10, 32'h1);
        ack(4'h0);
        wr(8'h14, 32'h1);
        wr(8'h10, 32'h40);
        ack(4'h6);
        wr(8'h14, 32'h40);
        chk(irq_out, 32'h1);
        clr_evt;
        idle;
        wr(8'h00, 32'h82);
        next_single <= 1'b1;
        fork
            wr(8'h00, 32'h80);
            ev(12'h002);
        join
        ack(4'h1);
        rd(8'h00, 32'h80);
        wr(8'h14, 32'h2);
        idle;
        next_single <= 1'b0;
        wr(8'h00, 32'h82);
        fork
            wr(8'h00, 32'h80);
            ev(12'h002);
        join
        repeat (20) @(posedge ref_clk);
        chk(32'(acks.size()), 32'h0);
        rd(8'h10, 32'h2);
        wr(8'h14, 32'h2);
        complete_run;
    end
endmodule
